// file: core/ctx_pkg.sv
package ctx_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [11:0] OFS_PHY_CONTROL = 12'h000;
    localparam logic [11:0] OFS_IN_PHASE_DAC_OVERRIDE = 12'h004;
    localparam logic [11:0] OFS_QUADRATURE_DAC_OVERRIDE = 12'h008;
    localparam logic [11:0] OFS_FRAME_LENGTH_LOW = 12'h00C;
    localparam logic [11:0] OFS_FRAME_LENGTH_HIGH = 12'h010;
    localparam logic [11:0] OFS_COMMAND = 12'h014;
    localparam logic [11:0] OFS_CHIP_MODE = 12'h018;
    localparam logic [11:0] OFS_STATUS = 12'h01C;

    // Reset values.
    localparam logic [7:0] RST_PHY_CONTROL = 8'h54;
    localparam logic [7:0] RST_DAC_OVERRIDE = 8'h00;
    localparam logic [7:0] RST_FRAME_LENGTH = 8'h00;
    localparam logic [7:0] RST_CHIP_MODE = 8'h00;

    // Field positions of the PHY control register.
    localparam int PC_CONTINUOUS = 7;
    localparam int PC_FILTER = 6;
    localparam int PC_VALID = 5;
    localparam int PC_AUTO_FCS = 4;
    localparam int PC_FCS_TYPE = 3;
    localparam int PC_BB_EN = 2;

    // Field positions of the DAC override registers.
    localparam int DAC_ENABLE = 7;
    localparam int DAC_CODE_MSB = 6;

    // DAC code limits.
    localparam logic [6:0] DAC_CODE_MAX = 7'h7E;
    localparam logic [6:0] DAC_CODE_ILLEGAL = 7'h7F;

    // Command codes in the command register.
    localparam logic [2:0] CMD_NOP = 3'h0;
    localparam logic [2:0] CMD_RADIO_OFF = 3'h2;
    localparam logic [2:0] CMD_PREPARE = 3'h3;
    localparam logic [2:0] CMD_TX = 3'h4;

    // Chip mode that starts a plain carrier.
    localparam logic [7:0] CHIP_MODE_CARRIER = 8'h01;

    // Checksum sizes in octets.
    localparam logic [15:0] FCS_LEN_16 = 16'h0002;
    localparam logic [15:0] FCS_LEN_32 = 16'h0004;
    localparam logic [31:0] CRC32_INIT = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC16_INIT = 32'h0000_0000;
    localparam logic [31:0] CRC32_POLY = 32'hEDB8_8320;
    localparam logic [15:0] CRC16_POLY = 16'h8408;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_PREP,
        ST_HDR,
        ST_PAY,
        ST_CW
    } ctx_state_t;

    // Keeps an override code inside the legal range.
    function automatic logic [6:0] ctx_clamp_code(input logic [6:0] code);
        ctx_clamp_code = (code == DAC_CODE_ILLEGAL) ? DAC_CODE_MAX : code;
    endfunction : ctx_clamp_code
endpackage : ctx_pkg

// file: core/ctx_fcs.sv
module ctx_fcs
    import ctx_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_load,
    input wire logic i_type16,
    input wire logic [7:0] i_data,
    output logic [31:0] o_fcs
);
    logic [31:0] crc;

    function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h00_0000, d};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ CRC32_POLY) : (r >> 1);
        end
        crc32_byte = r;
    endfunction : crc32_byte

    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ CRC16_POLY) : (r >> 1);
        end
        crc16_byte = r;
    endfunction : crc16_byte

    // Runs a reflected checksum over each payload octet that is not replaced.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            crc <= CRC32_INIT;
        end else if (i_clear) begin
            crc <= i_type16 ? CRC16_INIT : CRC32_INIT;
        end else if (i_load) begin
            if (i_type16) begin
                crc <= {16'h0000, crc16_byte(crc[15:0], i_data)};
            end else begin
                crc <= crc32_byte(crc, i_data);
            end
        end
    end

    assign o_fcs = i_type16 ? {16'h0000, crc[15:0]} : ~crc;
endmodule : ctx_fcs

// file: core/ctx_dac_mux.sv
module ctx_dac_mux
    import ctx_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_over_i,
    input wire logic [7:0] i_over_q,
    input wire logic [6:0] i_mod_i,
    input wire logic [6:0] i_mod_q,
    output logic [6:0] o_dac_i,
    output logic [6:0] o_dac_q
);
    // Each DAC input picks the stored code or the modulator independently.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dac_i <= 7'h3F;
            o_dac_q <= 7'h3F;
        end else begin
            o_dac_i <= i_over_i[DAC_ENABLE] ? i_over_i[DAC_CODE_MSB:0] : i_mod_i; // see R10 R13
            o_dac_q <= i_over_q[DAC_ENABLE] ? i_over_q[DAC_CODE_MSB:0] : i_mod_q; // see R11 R13
        end
    end
endmodule : ctx_dac_mux

// file: core/ctx_tx_test.sv
// Overview of operation
// R1 - Continuous enable set selects repeated payload mode
// R2 - Host prepares transmitter before issuing transmit
// R3 - Send headers once, then payload repeatedly
// R4 - Payload length is high and low length
// R5 - Auto checksum replaces last payload octets
// R6 - Clearing enable finishes payload, then prepared
// R7 - Frame buffer read restarts each repetition
// R8 - Pad bits only in final repetition
// R9 - Radio off command stops transmission at once
// R10 - In-phase override code replaces modulator output
// R11 - Quadrature override code replaces modulator independently
// R12 - Override codes limited to 0x00 through 0x7E
// R13 - Code 0x3F zero, 0x00 min, 0x7E max
// R14 - Both overrides in transmit give LO carrier
// R15 - Chip mode one plus transmit starts carrier
// R16 - Host suggests codes 0x7E and 0x3F
// R17 - Host setup for frame continuous transmit
// R18 - Host setup for carrier in chip mode
// R19 - Continuous enable bit 7, checksum flag read-only
// R20 - Override enable bit 7, code bits 6:0
// R21 - After radio off abort, stay idle off
//
// Decided for this implementation: the placing of the registers and the APB register port.
module ctx_tx_test
    import ctx_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [10:0] o_fb_addr,
    input wire logic [7:0] i_fb_data,
    output logic o_hdr_start,
    input wire logic i_hdr_done,
    output logic [7:0] o_tx_octet,
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    output logic o_last_rep,
    input wire logic i_pad_mode,
    output logic o_pad_req,
    input wire logic [6:0] i_mod_i,
    input wire logic [6:0] i_mod_q,
    output logic [6:0] o_dac_i,
    output logic [6:0] o_dac_q,
    input wire logic i_checksum_ok,
    output logic [7:0] o_phy_control,
    output logic o_tx_active,
    output logic o_carrier
);
    logic [7:0] phy_control;
    logic [7:0] in_phase_dac_override;
    logic [7:0] quadrature_dac_override;
    logic [7:0] frame_length_low;
    logic [7:0] frame_length_high;
    logic [7:0] chip_mode_select;
    logic checksum_valid_flag;
    ctx_state_t state;
    logic cont_run;
    logic [15:0] cnt;
    logic [15:0] reps;
    logic [15:0] len;
    logic [15:0] fcs_len;
    logic [15:0] data_end;
    logic [15:0] fcs_idx;
    logic [31:0] fcs;
    logic [7:0] fcs_byte;
    logic acc_wr;
    logic cmd_wr;
    logic [2:0] cmd;
    logic slot;
    logic fcs_clear;
    logic fcs_load;
    logic rep_end;
    logic keep_going;
    logic [31:0] next_rdata;
    logic next_err;

    // Bus access and command decode.
    assign acc_wr = i_psel && i_penable && o_pready && i_pwrite;
    assign cmd_wr = acc_wr && (i_paddr == OFS_COMMAND);
    assign cmd = cmd_wr ? i_pwdata[2:0] : CMD_NOP;

    // Payload geometry.
    assign len = {frame_length_high, frame_length_low}; // see R4
    assign fcs_len = phy_control[PC_FCS_TYPE] ? FCS_LEN_16 : FCS_LEN_32;
    assign data_end = !phy_control[PC_AUTO_FCS] ? len :
                      (len > fcs_len) ? (len - fcs_len) : 16'h0000; // see R5
    assign fcs_idx = cnt - data_end;
    assign fcs_byte = 8'(fcs >> {fcs_idx[1:0], 3'b000});
    assign slot = !o_tx_valid || i_tx_ready;
    assign rep_end = (state == ST_PAY) && slot && (cnt >= len);
    assign keep_going = cont_run && phy_control[PC_CONTINUOUS]; // see R1 R6
    assign fcs_load = (state == ST_PAY) && slot && (cnt < data_end);
    assign fcs_clear = (state != ST_PAY) || rep_end;

    ctx_fcs u_fcs (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_clear(fcs_clear),
        .i_load(fcs_load),
        .i_type16(phy_control[PC_FCS_TYPE]),
        .i_data(i_fb_data),
        .o_fcs(fcs)
    );

    ctx_dac_mux u_dac (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_over_i(in_phase_dac_override),
        .i_over_q(quadrature_dac_override),
        .i_mod_i(i_mod_i),
        .i_mod_q(i_mod_q),
        .o_dac_i(o_dac_i),
        .o_dac_q(o_dac_q)
    );

    // Read data decode.
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (i_paddr == OFS_PHY_CONTROL) begin
            next_rdata[7:0] = phy_control;
        end else if (i_paddr == OFS_IN_PHASE_DAC_OVERRIDE) begin
            next_rdata[7:0] = in_phase_dac_override;
        end else if (i_paddr == OFS_QUADRATURE_DAC_OVERRIDE) begin
            next_rdata[7:0] = quadrature_dac_override;
        end else if (i_paddr == OFS_FRAME_LENGTH_LOW) begin
            next_rdata[7:0] = frame_length_low;
        end else if (i_paddr == OFS_FRAME_LENGTH_HIGH) begin
            next_rdata[7:0] = frame_length_high;
        end else if (i_paddr == OFS_COMMAND) begin
            next_rdata = 32'h0000_0000;
        end else if (i_paddr == OFS_CHIP_MODE) begin
            next_rdata[7:0] = chip_mode_select;
        end else if (i_paddr == OFS_STATUS) begin
            next_rdata = {reps, 13'h0000, state};
        end else begin
            next_err = 1'b1;
        end
    end

    // The answer is prepared in the setup cycle and shown in the first access cycle.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && next_err;
            o_prdata <= (i_psel && !i_penable && !i_pwrite) ? next_rdata : 32'h0000_0000;
        end
    end

    // Software writable configuration.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phy_control <= RST_PHY_CONTROL;
            in_phase_dac_override <= RST_DAC_OVERRIDE;
            quadrature_dac_override <= RST_DAC_OVERRIDE;
            frame_length_low <= RST_FRAME_LENGTH;
            frame_length_high <= RST_FRAME_LENGTH;
            chip_mode_select <= RST_CHIP_MODE;
        end else begin
            phy_control[PC_VALID] <= checksum_valid_flag; // see R19
            if (acc_wr && i_paddr == OFS_PHY_CONTROL) begin
                phy_control[7:6] <= i_pwdata[7:6]; // see R19
                phy_control[4:0] <= i_pwdata[4:0];
            end
            if (acc_wr && i_paddr == OFS_IN_PHASE_DAC_OVERRIDE) begin
                in_phase_dac_override <= {i_pwdata[DAC_ENABLE],
                                          ctx_clamp_code(i_pwdata[DAC_CODE_MSB:0])}; // see R12 R20
            end
            if (acc_wr && i_paddr == OFS_QUADRATURE_DAC_OVERRIDE) begin
                quadrature_dac_override <= {i_pwdata[DAC_ENABLE],
                                            ctx_clamp_code(i_pwdata[DAC_CODE_MSB:0])}; // see R12 R20
            end
            if (acc_wr && i_paddr == OFS_FRAME_LENGTH_LOW) begin
                frame_length_low <= i_pwdata[7:0];
            end
            if (acc_wr && i_paddr == OFS_FRAME_LENGTH_HIGH) begin
                frame_length_high <= i_pwdata[7:0];
            end
            if (acc_wr && i_paddr == OFS_CHIP_MODE) begin
                chip_mode_select <= i_pwdata[7:0];
            end
        end
    end

    // The read-only checksum flag follows the receive checker.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            checksum_valid_flag <= 1'b0;
        end else begin
            checksum_valid_flag <= i_checksum_ok;
        end
    end

    // Transmit state machine.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_OFF;
            cont_run <= 1'b0;
        end else if (cmd == CMD_RADIO_OFF) begin
            state <= ST_OFF; // see R9 R21
            cont_run <= 1'b0;
        end else begin
            case (state)
                ST_OFF: begin
                    if (cmd == CMD_PREPARE) begin
                        state <= ST_PREP;
                    end
                end
                ST_PREP: begin
                    if (cmd == CMD_TX) begin // see R2
                        if (chip_mode_select == CHIP_MODE_CARRIER) begin
                            state <= ST_CW; // see R15
                        end else begin
                            state <= ST_HDR; // see R3
                            cont_run <= phy_control[PC_CONTINUOUS]; // see R1
                        end
                    end
                end
                ST_HDR: begin
                    if (i_hdr_done) begin
                        state <= ST_PAY;
                    end
                end
                ST_PAY: begin
                    if (rep_end && !keep_going) begin
                        state <= ST_PREP; // see R6
                        cont_run <= 1'b0;
                    end
                end
                ST_CW: begin
                    state <= ST_CW;
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
        end
    end

    // Payload octet stream from the frame buffer.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 16'h0000;
            reps <= 16'h0000;
            o_tx_octet <= 8'h00;
            o_tx_valid <= 1'b0;
        end else if (state != ST_PAY || cmd == CMD_RADIO_OFF) begin
            cnt <= 16'h0000; // see R9
            o_tx_valid <= 1'b0;
            if (state == ST_PREP) begin
                reps <= 16'h0000;
            end
        end else if (rep_end) begin
            cnt <= 16'h0000; // see R7
            o_tx_valid <= 1'b0;
            reps <= reps + 16'h0001; // see R3
        end else if (slot) begin
            o_tx_octet <= (cnt >= data_end) ? fcs_byte : i_fb_data; // see R5
            o_tx_valid <= 1'b1;
            cnt <= cnt + 16'h0001;
        end
    end

    assign o_fb_addr = cnt[10:0]; // see R7

    // Header request, final repetition and pad request.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hdr_start <= 1'b0;
            o_last_rep <= 1'b0;
            o_pad_req <= 1'b0;
        end else begin
            o_hdr_start <= (state == ST_PREP) && (cmd == CMD_TX) &&
                           (chip_mode_select != CHIP_MODE_CARRIER); // see R3
            o_last_rep <= (state == ST_PAY) && !keep_going;
            o_pad_req <= rep_end && !keep_going && i_pad_mode &&
                         (cmd != CMD_RADIO_OFF); // see R8
        end
    end

    // Status outputs.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_active <= 1'b0;
            o_carrier <= 1'b0;
            o_phy_control <= RST_PHY_CONTROL;
        end else begin
            o_tx_active <= (state == ST_HDR) || (state == ST_PAY) || (state == ST_CW);
            o_carrier <= ((state == ST_PAY) || (state == ST_CW) || (state == ST_HDR)) &&
                         in_phase_dac_override[DAC_ENABLE] &&
                         quadrature_dac_override[DAC_ENABLE]; // see R14
            o_phy_control <= phy_control;
        end
    end
endmodule : ctx_tx_test

// file: test/ctx_tx_test_monitor.sv
module ctx_tx_test_monitor
    import ctx_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [7:0] o_tx_octet,
    input wire logic o_tx_valid,
    input wire logic i_tx_ready,
    input wire logic o_hdr_start,
    input wire logic o_last_rep,
    input wire logic i_pad_mode,
    input wire logic o_pad_req,
    input wire logic i_checksum_ok,
    input wire logic [7:0] o_phy_control,
    input wire logic o_tx_active,
    input wire logic o_carrier
);
    timeunit 1ns;
    timeprecision 1ns;
    logic off_wr;
    // A radio off write may drop an octet that was never accepted.
    assign off_wr = i_psel && i_penable && i_pwrite && o_pready &&
                    (i_paddr == OFS_COMMAND) && (i_pwdata[2:0] == CMD_RADIO_OFF);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_wr;
        i_psel && i_penable && i_pwrite && o_pready;
    endsequence
    sequence s_ctl_wr;
        s_wr ##0 (i_paddr == OFS_PHY_CONTROL);
    endsequence
    sequence s_off_wr;
        s_wr ##0 (i_paddr == OFS_COMMAND && i_pwdata[2:0] == CMD_RADIO_OFF);
    endsequence
    a_ready_in_access: assert property (i_psel && !i_penable |=> o_pready)
        else $error("No ready in access cycle.");
    a_ready_single: assert property (o_pready |=> !o_pready)
        else $error("Ready held too long.");
    a_err_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("Error without ready.");
    a_ctl_bit_write: assert property (s_ctl_wr |-> ##2
        (o_phy_control[PC_CONTINUOUS] == $past(i_pwdata[PC_CONTINUOUS], 2)))
        else $error("Continuous bit not written.");
    a_flag_follow: assert property ($rose(i_checksum_ok) |-> ##[2:3] o_phy_control[PC_VALID])
        else $error("Checksum flag not shown.");
    a_octet_hold: assert property (o_tx_valid && !i_tx_ready && !off_wr |=>
        o_tx_valid && $stable(o_tx_octet))
        else $error("Octet dropped before acceptance.");
    a_hdr_pulse: assert property (o_hdr_start |=> !o_hdr_start)
        else $error("Header start longer than one cycle.");
    a_pad_final: assert property (o_pad_req |-> $past(o_last_rep) && i_pad_mode ##1 !o_pad_req)
        else $error("Pad request outside final repetition.");
    a_valid_active: assert property (o_tx_valid |-> o_tx_active)
        else $error("Octet offered while idle.");
    a_carrier_quiet: assert property (o_carrier |-> o_tx_active && !o_tx_valid)
        else $error("Carrier with payload stream.");
    a_off_stops: assert property (s_off_wr |-> ##2 (!o_tx_valid && !o_tx_active))
        else $error("Transmit not stopped by radio off.");
endmodule : ctx_tx_test_monitor

bind ctx_tx_test ctx_tx_test_monitor u_mon (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_tx_octet(o_tx_octet),
    .o_tx_valid(o_tx_valid),
    .i_tx_ready(i_tx_ready),
    .o_hdr_start(o_hdr_start),
    .o_last_rep(o_last_rep),
    .i_pad_mode(i_pad_mode),
    .o_pad_req(o_pad_req),
    .i_checksum_ok(i_checksum_ok),
    .o_phy_control(o_phy_control),
    .o_tx_active(o_tx_active),
    .o_carrier(o_carrier)
);

// file: test/ctx_far_model.sv
module ctx_far_model
    import ctx_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_slow,
    input wire logic [10:0] i_fb_addr,
    input wire logic i_hdr_start,
    output logic [7:0] o_fb_data,
    output logic o_hdr_done,
    output logic o_tx_ready,
    output logic [6:0] o_mod_i,
    output logic [6:0] o_mod_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] hdr_cnt;
    // Buffer contents are a fixed pattern of the address, read without delay.
    assign o_fb_data = i_fb_addr[7:0] ^ 8'h5A;
    assign o_mod_i = 7'h11;
    assign o_mod_q = 7'h22;
    // Headers take four cycles, then a one-cycle done pulse.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hdr_cnt <= 3'h0;
            o_hdr_done <= 1'b0;
        end else begin
            o_hdr_done <= (hdr_cnt == 3'h1);
            if (i_hdr_start) begin
                hdr_cnt <= 3'h4;
            end else if (hdr_cnt != 3'h0) begin
                hdr_cnt <= hdr_cnt - 3'h1;
            end
        end
    end
    // A slow modulator accepts an octet only every other cycle.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_ready <= 1'b0;
        end else begin
            o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
        end
    end
endmodule : ctx_far_model

// file: test/testbench.sv
module testbench
    import ctx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, slow, pad_mode, cks_ok, fcs_on;
    logic hdr_start, hdr_done, tx_valid, tx_ready, last_rep, pad_req, tx_active, carrier;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [10:0] fb_addr;
    logic [7:0] fb_data, tx_octet, phy_ctl;
    logic [6:0] mod_i, mod_q, dac_i, dac_q;
    int mismatches, total_checks, acc, len, pads;
    ctx_tx_test dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_fb_addr(fb_addr), .i_fb_data(fb_data),
        .o_hdr_start(hdr_start), .i_hdr_done(hdr_done), .o_tx_octet(tx_octet),
        .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_last_rep(last_rep),
        .i_pad_mode(pad_mode), .o_pad_req(pad_req), .i_mod_i(mod_i), .i_mod_q(mod_q),
        .o_dac_i(dac_i), .o_dac_q(dac_q), .i_checksum_ok(cks_ok), .o_phy_control(phy_ctl),
        .o_tx_active(tx_active), .o_carrier(carrier));
    ctx_far_model far (.i_core_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_fb_addr(fb_addr),
        .i_hdr_start(hdr_start), .o_fb_data(fb_data), .o_hdr_done(hdr_done),
        .o_tx_ready(tx_ready), .o_mod_i(mod_i), .o_mod_q(mod_q));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk
    task automatic wait_state(input logic [2:0] s);
        for (int i = 0; i < 400; i++) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (rd[2:0] === s) break;
        end
        chk(rd[2:0], s);
    endtask : wait_state
    task automatic wait_acc(input int n);
        for (int i = 0; i < 5000 && acc < n; i++) @(posedge clk);
    endtask : wait_acc
    // Every accepted octet must be the buffer octet at its payload index, or the expected checksum octet when fcs_on is set.
    always @(posedge clk) begin
        if (rst_n && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            chk(tx_octet, fcs_on ? 8'(24'hFD_DF5A >> (8 * (acc % len))) :
                8'(acc % len) ^ 8'h5A);
            acc <= acc + 1;
        end
        if (pad_req === 1'b1) pads <= pads + 1;
    end
    task automatic t_reset;
        chk(dac_i, 7'h3F);
        chk(dac_q, 7'h3F);
        rst_n <= 1'b1;
        pad_mode <= 1'b1;
        @(posedge clk);
        rd_chk(OFS_PHY_CONTROL, 32'h0000_0054);
        rd_chk(OFS_IN_PHASE_DAC_OVERRIDE, 32'h0000_0000);
        rd_chk(12'h020, 32'h0000_0000);
        chk(err, 1'b1);
        cks_ok <= 1'b1;
        apb(1'b1, OFS_PHY_CONTROL, 32'h0000_0054);
        rd_chk(OFS_PHY_CONTROL, 32'h0000_0074);
    endtask : t_reset
    task automatic t_dac;
        apb(1'b1, OFS_IN_PHASE_DAC_OVERRIDE, 32'h0000_00FE);
        apb(1'b1, OFS_QUADRATURE_DAC_OVERRIDE, 32'h0000_007F);
        rd_chk(OFS_QUADRATURE_DAC_OVERRIDE, 32'h0000_007E);
        chk(dac_i, 7'h7E);
        chk(dac_q, 7'h22);
        apb(1'b1, OFS_QUADRATURE_DAC_OVERRIDE, 32'h0000_00BF);
        apb(1'b1, OFS_IN_PHASE_DAC_OVERRIDE, 32'h0000_0000);
        tick(2);
        chk(dac_q, 7'h3F);
        chk(dac_i, 7'h11);
        apb(1'b1, OFS_QUADRATURE_DAC_OVERRIDE, 32'h0000_0000);
    endtask : t_dac
    task automatic t_cont;
        slow <= 1'b1;
        len = 261;
        acc = 0;
        pads = 0;
        apb(1'b1, OFS_CHIP_MODE, 32'h0000_0000);
        apb(1'b1, OFS_FRAME_LENGTH_LOW, 32'h0000_0005);
        apb(1'b1, OFS_FRAME_LENGTH_HIGH, 32'h0000_0001);
        apb(1'b1, OFS_PHY_CONTROL, 32'h0000_00C4);
        apb(1'b1, OFS_COMMAND, 32'(CMD_PREPARE));
        wait_state(3'h1);
        apb(1'b1, OFS_COMMAND, 32'(CMD_TX));
        wait_acc(2 * len + 2);
        apb(1'b1, OFS_PHY_CONTROL, 32'h0000_0044);
        wait_state(3'h1);
        chk(acc, 3 * len);
        chk(pads, 1);
    endtask : t_cont
    task automatic t_fcs;
        acc = 0;
        len = 3;
        fcs_on = 1'b1;
        apb(1'b1, OFS_FRAME_LENGTH_HIGH, 32'h0000_0000);
        apb(1'b1, OFS_FRAME_LENGTH_LOW, 32'h0000_0003);
        apb(1'b1, OFS_PHY_CONTROL, 32'h0000_005C);
        apb(1'b1, OFS_COMMAND, 32'(CMD_TX));
        wait_state(3'h1);
        chk(acc, 3);
        fcs_on = 1'b0;
    endtask : t_fcs
    task automatic t_abort;
        int n;
        slow <= 1'b0;
        acc = 0;
        apb(1'b1, OFS_PHY_CONTROL, 32'h0000_00C4);
        apb(1'b1, OFS_COMMAND, 32'(CMD_TX));
        wait_acc(20);
        apb(1'b1, OFS_COMMAND, 32'(CMD_RADIO_OFF));
        tick(1);
        n = acc;
        tick(8);
        chk(acc, n);
        chk(tx_valid, 1'b0);
        wait_state(3'h0);
    endtask : t_abort
    task automatic t_carrier;
        apb(1'b1, OFS_CHIP_MODE, 32'(CHIP_MODE_CARRIER));
        apb(1'b1, OFS_IN_PHASE_DAC_OVERRIDE, 32'h0000_00FE);
        apb(1'b1, OFS_QUADRATURE_DAC_OVERRIDE, 32'h0000_00BF);
        apb(1'b1, OFS_COMMAND, 32'(CMD_PREPARE));
        wait_state(3'h1);
        apb(1'b1, OFS_COMMAND, 32'(CMD_TX));
        wait_state(3'h4);
        chk(carrier, 1'b1);
        chk(tx_valid, 1'b0);
        chk({dac_i, dac_q}, {7'h7E, 7'h3F});
        apb(1'b1, OFS_COMMAND, 32'(CMD_RADIO_OFF));
        wait_state(3'h0);
        chk(carrier, 1'b0);
    endtask : t_carrier
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        {rst_n, psel, penable, pwrite, slow, pad_mode, cks_ok, fcs_on} = 8'h00;
        paddr = 12'h0;
        pwdata = 32'h0;
        len = 1;
        repeat (6) @(posedge clk);
        t_reset();
        t_dac();
        t_cont();
        t_fcs();
        t_abort();
        t_carrier();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule : testbench
